// ---- hw/pbs_consts.svh ----
// Timing constants and pixel layout for the panel black-video and sequencing monitor.
// Assumes a 100 MHz clock; included by the package, the panel sequencing module and the bench.
`ifndef PBS_CONSTS_SVH
`define PBS_CONSTS_SVH
`define PBS_CLOCK_MHZ 100
`define PBS_GAP_MS 1
`define PBS_GAP_CYCLES (`PBS_GAP_MS * 1000 * `PBS_CLOCK_MHZ)
`define PBS_BLACK_MAX_MS 200
`define PBS_BLACK_MAX_CYCLES (`PBS_BLACK_MAX_MS * 1000 * `PBS_CLOCK_MHZ)
`define PBS_HPD_MAX_MS 200
`define PBS_HPD_MAX_CYCLES (`PBS_HPD_MAX_MS * 1000 * `PBS_CLOCK_MHZ)
`define PBS_LOSS_MAX_MS 50
`define PBS_LOSS_MAX_CYCLES (`PBS_LOSS_MAX_MS * 1000 * `PBS_CLOCK_MHZ)
`define PBS_HPD_DELAY_MS 100
`define PBS_HPD_DELAY_CYCLES (`PBS_HPD_DELAY_MS * 1000 * `PBS_CLOCK_MHZ)
`define PBS_LOSS_DELAY_MS 40
`define PBS_LOSS_DELAY_CYCLES (`PBS_LOSS_DELAY_MS * 1000 * `PBS_CLOCK_MHZ)
`define PBS_PIXEL_W 18
`define PBS_BLACK_PIXEL 18'h00000
`define PBS_NOSTREAM_BIT 3
`define PBS_CNT_W 32
`endif

// ---- hw/pbs_pkg.sv ----
// Types shared by the panel black-video and sequencing monitor.
// Assumes the constants header is present on the include path.
`include "pbs_consts.svh"
package pbs_pkg;
   typedef enum logic [1:0] {
      PBS_RAIL_OFF = 2'b00,
      PBS_RAIL_UP = 2'b01,
      PBS_DIM_ON = 2'b10,
      PBS_LIT = 2'b11
   } pbs_seq_type;
endpackage

// ---- hw/pbs_sync.sv ----
// Three-stage input synchroniser with agreement filter.
// Assumes the input is asynchronous to clock.
`timescale 1ns/1ps
module pbs_sync (
   input wire logic clock,
   input wire logic reset,
   input wire logic pinIn,
   output logic level
);
   logic [2:0] stage_r;
   logic [2:0] stage_nxt;
   logic level_r;
   logic level_nxt;

   // The first stage feeds only the second; the change counts once stages two and three agree.
   always_comb begin
      stage_nxt = {stage_r[1:0], pinIn};
      level_nxt = (stage_r[1] == stage_r[2]) ? stage_r[2] : level_r;
   end

   // Registers the shift chain and the filtered level.
   always_ff @(posedge clock) begin
      if (reset) begin
         stage_r <= 3'h0;
         level_r <= 1'b0;
      end else begin
         stage_r <= stage_nxt;
         level_r <= level_nxt;
      end
   end

   assign level = level_r;
endmodule // pbs_sync

// ---- hw/pbs_panel_seq.sv ----
// Panel sink logic: autonomous black video, hot-plug detect and AUX readiness, sequencing watch.
// Assumes reset follows the panel logic supply; backlight pins are asynchronous and synchronised here.
`timescale 1ns/1ps
`include "pbs_consts.svh"
module pbs_panel_seq
   import pbs_pkg::*;
#(
   parameter logic [`PBS_CNT_W-1:0] GAP_CYCLES = `PBS_GAP_CYCLES,
   parameter logic [`PBS_CNT_W-1:0] HPD_DELAY = `PBS_HPD_DELAY_CYCLES,
   parameter logic [`PBS_CNT_W-1:0] LOSS_DELAY = `PBS_LOSS_DELAY_CYCLES
) (
   input wire logic clock,
   input wire logic reset,
   input wire logic ledRailPin,
   input wire logic dimmingPin,
   input wire logic backlightEnPin,
   input wire logic linkActive,
   input wire logic msaValid,
   input wire logic timingValid,
   input wire logic [7:0] streamFlags,
   input wire logic streamFlagsValid,
   input wire logic [`PBS_PIXEL_W-1:0] pixelIn,
   input wire logic blackDisable,
   input wire logic auxRequest,
   output logic [`PBS_PIXEL_W-1:0] pixelOut,
   output logic blackActive,
   output logic hotPlugDetect,
   output logic auxReady,
   output logic auxReply,
   output logic sinkStatus,
   output logic seqViolation
);
   logic ledRail;
   logic dimming;
   logic backlightEn;
   logic [`PBS_CNT_W-1:0] upCnt_r, upCnt_nxt;
   logic hpd_r, hpd_nxt;
   logic streamAbsent_r, streamAbsent_nxt;
   logic [`PBS_CNT_W-1:0] lossCnt_r, lossCnt_nxt;
   logic black_r, black_nxt;
   logic [`PBS_PIXEL_W-1:0] pix_r, pix_nxt;
   logic reply_r, reply_nxt;
   pbs_seq_type seq_r, seq_nxt;
   logic [`PBS_CNT_W-1:0] gapCnt_r, gapCnt_nxt;
   logic viol_r, viol_nxt;
   logic seqFromLit_r, seqFromLit_nxt;
   logic status_r, status_nxt;
   logic videoGood;

   // Backlight pins come from the source's controller and are synchronised.
   pbs_sync syncRail (.clock(clock), .reset(reset), .pinIn(ledRailPin), .level(ledRail));
   pbs_sync syncDim (.clock(clock), .reset(reset), .pinIn(dimmingPin), .level(dimming));
   pbs_sync syncEn (.clock(clock), .reset(reset), .pinIn(backlightEnPin), .level(backlightEn));

   // Video counts as good only with link data, valid attributes and sane timing.
   assign videoGood = linkActive && msaValid && timingValid && !streamAbsent_r;

   // Power-up timer raises hot-plug detect; AUX is served from reset release onward.
   always_comb begin
      upCnt_nxt = upCnt_r;
      hpd_nxt = hpd_r;
      if (upCnt_r < HPD_DELAY) begin
         upCnt_nxt = upCnt_r + 32'h1;
      end else begin
         hpd_nxt = 1'b1;
      end
      reply_nxt = auxRequest;
   end

   // Stream-absent flag, loss timer and the black decision.
   always_comb begin
      streamAbsent_nxt = streamAbsent_r;
      if (streamFlagsValid) begin
         streamAbsent_nxt = streamFlags[`PBS_NOSTREAM_BIT];
      end
      lossCnt_nxt = lossCnt_r;
      if (videoGood) begin
         lossCnt_nxt = 32'h0;
      end else if (lossCnt_r < LOSS_DELAY) begin
         lossCnt_nxt = lossCnt_r + 32'h1;
      end
      black_nxt = black_r;
      if (blackDisable) begin
         black_nxt = 1'b0;
      end else if (streamAbsent_r || (streamFlagsValid && streamFlags[`PBS_NOSTREAM_BIT])) begin
         black_nxt = 1'b1;
      end else if (!videoGood && lossCnt_r >= LOSS_DELAY) begin
         black_nxt = 1'b1;
      end else if (videoGood) begin
         black_nxt = 1'b0;
      end
      pix_nxt = black_nxt ? `PBS_BLACK_PIXEL : pixelIn;
      // Status is registered beside black so that the output comes from a flip-flop.
      status_nxt = !black_nxt;
   end

   // Sequencing watch: flags a source that breaks the 1 ms gaps.
   always_comb begin
      seq_nxt = seq_r;
      viol_nxt = viol_r;
      gapCnt_nxt = (gapCnt_r < GAP_CYCLES) ? gapCnt_r + 32'h1 : gapCnt_r;
      case (seq_r)
         PBS_RAIL_OFF: begin
            if (ledRail) begin
               seq_nxt = PBS_RAIL_UP;
               gapCnt_nxt = 32'h0;
            end
         end
         PBS_RAIL_UP: begin
            if (!ledRail) begin
               if (gapCnt_r < GAP_CYCLES) viol_nxt = 1'b1;
               seq_nxt = PBS_RAIL_OFF;
            end else if (dimming) begin
               if (gapCnt_r < GAP_CYCLES) viol_nxt = 1'b1;
               seq_nxt = PBS_DIM_ON;
               gapCnt_nxt = 32'h0;
            end
         end
         PBS_DIM_ON: begin
            if (backlightEn) begin
               if (gapCnt_r < GAP_CYCLES) viol_nxt = 1'b1;
               seq_nxt = PBS_LIT;
               gapCnt_nxt = 32'h0;
            end else if (!dimming) begin
               seq_nxt = PBS_RAIL_UP;
               gapCnt_nxt = 32'h0;
            end
         end
         PBS_LIT: begin
            if (!backlightEn) begin
               seq_nxt = PBS_DIM_ON;
               gapCnt_nxt = 32'h0;
            end
         end
         default: seq_nxt = PBS_RAIL_OFF;
      endcase
      if (seq_r == PBS_DIM_ON && !dimming && !backlightEn && gapCnt_r < GAP_CYCLES && seqFromLit_r) begin
         viol_nxt = 1'b1;
      end
   end

   // Remembers that the dimming stage was entered from the lit state.
   always_comb begin
      seqFromLit_nxt = seqFromLit_r;
      if (seq_r == PBS_LIT && !backlightEn) seqFromLit_nxt = 1'b1;
      else if (seq_r != PBS_DIM_ON) seqFromLit_nxt = 1'b0;
   end

   // Black starts active at reset, so black video begins at once after supply rise.
   always_ff @(posedge clock) begin
      if (reset) begin
         upCnt_r <= 32'h0;
         hpd_r <= 1'b0;
         reply_r <= 1'b0;
         streamAbsent_r <= 1'b0;
         lossCnt_r <= 32'h0;
         black_r <= 1'b1;
         pix_r <= `PBS_BLACK_PIXEL;
         seq_r <= PBS_RAIL_OFF;
         gapCnt_r <= 32'h0;
         viol_r <= 1'b0;
         seqFromLit_r <= 1'b0;
         status_r <= 1'b0;
      end else begin
         upCnt_r <= upCnt_nxt;
         hpd_r <= hpd_nxt;
         reply_r <= reply_nxt;
         streamAbsent_r <= streamAbsent_nxt;
         lossCnt_r <= lossCnt_nxt;
         black_r <= black_nxt;
         pix_r <= pix_nxt;
         seq_r <= seq_nxt;
         gapCnt_r <= gapCnt_nxt;
         viol_r <= viol_nxt;
         seqFromLit_r <= seqFromLit_nxt;
         status_r <= status_nxt;
      end
   end

   assign pixelOut = pix_r;
   assign blackActive = black_r;
   assign hotPlugDetect = hpd_r;
   assign auxReady = hpd_r;
   assign auxReply = reply_r;
   assign sinkStatus = status_r;
   assign seqViolation = viol_r;

   // Black output forces the pixel to gray level zero.
   chk_black_pixel_zero: assert property (@(posedge clock) disable iff (reset)
      blackActive |-> pixelOut == `PBS_BLACK_PIXEL) else $error("pixel not black");
   // Stream-absent flag gives black two cycles later unless disabled.
   chk_nostream_black: assert property (@(posedge clock) disable iff (reset)
      (streamFlagsValid && streamFlags[`PBS_NOSTREAM_BIT] && !blackDisable) ##1 !blackDisable |=> blackActive)
      else $error("no black on stream absent");
   // Debug control removes black.
   chk_disable_black: assert property (@(posedge clock) disable iff (reset)
      blackDisable |=> !blackActive) else $error("disable ignored");
   // Loss timer saturation implies black.
   chk_loss_black: assert property (@(posedge clock) disable iff (reset)
      (lossCnt_r >= LOSS_DELAY && !videoGood && !blackDisable) |=> blackActive)
      else $error("no black after loss");
   // Hot-plug detect only after the power-up delay.
   chk_hpd_timing: assert property (@(posedge clock) disable iff (reset)
      $rose(hotPlugDetect) |-> $past(upCnt_r) >= HPD_DELAY) else $error("hpd early");
   // Every AUX request is answered the next cycle.
   chk_aux_reply: assert property (@(posedge clock) disable iff (reset)
      auxRequest |=> auxReply) else $error("aux not answered");
   // Early dimming after rail rise is flagged.
   chk_dim_gap: assert property (@(posedge clock) disable iff (reset)
      (seq_r == PBS_RAIL_UP && ledRail && dimming && gapCnt_r < GAP_CYCLES) |=> seqViolation)
      else $error("dim gap missed");
   // Early enable after dimming is flagged.
   chk_en_gap: assert property (@(posedge clock) disable iff (reset)
      (seq_r == PBS_DIM_ON && backlightEn && gapCnt_r < GAP_CYCLES) |=> seqViolation)
      else $error("enable gap missed");
   // Early rail fall after dimming removal is flagged.
   chk_rail_gap: assert property (@(posedge clock) disable iff (reset)
      (seq_r == PBS_RAIL_UP && !ledRail && gapCnt_r < GAP_CYCLES) |=> seqViolation)
      else $error("rail gap missed");
   // Early dimming removal after the enable drops is flagged.
   chk_dim_off_gap: assert property (@(posedge clock) disable iff (reset)
      (seq_r == PBS_DIM_ON && seqFromLit_r && !dimming && !backlightEn && gapCnt_r < GAP_CYCLES) |=> seqViolation)
      else $error("dimming removal gap missed");
   // Status is the inverse of black.
   chk_status_black: assert property (@(posedge clock) disable iff (reset)
      sinkStatus != blackActive) else $error("status mismatch");
endmodule // pbs_panel_seq

// ---- tb/pbs_source_model.sv ----
// Source-side model: drives the LED rail, dimming and backlight enable levels in order.
// Assumes the bench raises lightOn to light the panel and sets the step spacing in clock cycles.
`timescale 1ns/1ps
module pbs_source_model (
   input wire logic clock,
   input wire logic lightOn,
   input wire logic [7:0] gap,
   output logic ledRailPin,
   output logic dimmingPin,
   output logic backlightEnPin
);
   // Waits the chosen spacing, then lands just after an edge.
   task automatic pause();
      repeat (gap) @(posedge clock);
      #1;
   endtask
   // Powers up and down in order; a short spacing is how the bench makes a faulty source.
   initial begin
      ledRailPin = 1'b0;
      dimmingPin = 1'b0;
      backlightEnPin = 1'b0;
      forever begin
         @(posedge clock iff lightOn);
         #1;
         ledRailPin = 1'b1;
         pause();
         dimmingPin = 1'b1;
         pause();
         backlightEnPin = 1'b1;
         @(posedge clock iff !lightOn);
         #1;
         backlightEnPin = 1'b0;
         pause();
         dimmingPin = 1'b0;
         pause();
         ledRailPin = 1'b0;
      end
   end
endmodule // pbs_source_model

// ---- tb/pbs_panel_seq_bench.sv ----
// Self-checking bench for the panel sink: blanking, hot-plug timing, AUX replies and backlight watch.
// Assumes shortened count parameters so every timed wait runs in tens of cycles.
`timescale 1ns/1ps
`include "pbs_consts.svh"
module pbs_panel_seq_bench;
   import pbs_pkg::*;
   localparam int GAP = 10;
   localparam int HPD = 20;
   localparam int LOSS = 20;
   localparam int LIMIT = 2000;
   localparam logic [`PBS_PIXEL_W-1:0] PIX = 18'h2a5c3;
   logic clock, reset, linkActive, msaValid, timingValid, streamFlagsValid, blackDisable, auxRequest, lightOn;
   logic ledRailPin, dimmingPin, backlightEnPin, blackActive, hotPlugDetect, auxReady, auxReply;
   logic sinkStatus, seqViolation;
   logic auxAnswered;
   logic [7:0] streamFlags, gap;
   logic [`PBS_PIXEL_W-1:0] pixelIn, pixelOut;
   int n_mismatch = 0, checks_done = 0, cycleCount = 0;
   pbs_panel_seq #(.GAP_CYCLES(`PBS_CNT_W'(GAP)), .HPD_DELAY(`PBS_CNT_W'(HPD)), .LOSS_DELAY(`PBS_CNT_W'(LOSS)))
   pbs_panel_seq_i (.clock(clock), .reset(reset), .ledRailPin(ledRailPin), .dimmingPin(dimmingPin),
      .backlightEnPin(backlightEnPin), .linkActive(linkActive), .msaValid(msaValid), .timingValid(timingValid),
      .streamFlags(streamFlags), .streamFlagsValid(streamFlagsValid), .pixelIn(pixelIn),
      .blackDisable(blackDisable), .auxRequest(auxRequest), .pixelOut(pixelOut), .blackActive(blackActive),
      .hotPlugDetect(hotPlugDetect), .auxReady(auxReady), .auxReply(auxReply), .sinkStatus(sinkStatus),
      .seqViolation(seqViolation));
   pbs_source_model pbs_source_model_i (.clock(clock), .lightOn(lightOn), .gap(gap), .ledRailPin(ledRailPin),
      .dimmingPin(dimmingPin), .backlightEnPin(backlightEnPin));
   // Free-running 100 MHz clock.
   initial begin
      clock = 1'b0;
      forever #5 clock = ~clock;
   end
   // Cuts a hung run short.
   always @(posedge clock) begin
      cycleCount++;
      if (cycleCount == LIMIT) begin
         n_mismatch++;
         close_out();
      end
   end
   // Moves to just after the n-th next rising edge.
   task automatic tick(int n);
      repeat (n) @(posedge clock);
      #1;
   endtask
   // Compares one observed value and reports a difference.
   task automatic check(string what, logic [`PBS_PIXEL_W-1:0] expVal, logic [`PBS_PIXEL_W-1:0] seenVal);
      checks_done++;
      if (seenVal !== expVal) begin
         n_mismatch++;
         $display("unexpected %s: expected %h, seen %h", what, expVal, seenVal);
      end
   endtask
   // Sends one stream flag byte as a single-cycle pulse.
   task automatic flags(logic [7:0] value);
      streamFlags = value;
      streamFlagsValid = 1'b1;
      tick(1);
      streamFlagsValid = 1'b0;
      tick(2);
   endtask
   // Polls AUX for one cycle and retries once when no reply came back.
   task automatic aux_poll(output logic answered);
      answered = 1'b0;
      for (int attempt = 0; attempt < 2; attempt++) begin
         if (answered !== 1'b1) begin
            auxRequest = 1'b1;
            tick(1);
            answered = auxReply;
            auxRequest = 1'b0;
            tick(1);
         end
      end
   endtask
   // Holds reset for 12 cycles and checks the outputs it forces.
   task automatic restart();
      reset = 1'b1;
      tick(12);
      check("black in reset", 1'b1, blackActive);
      check("pixel in reset", '0, pixelOut);
      check("hpd in reset", 1'b0, hotPlugDetect);
      check("status in reset", 1'b0, sinkStatus);
      check("violation in reset", 1'b0, seqViolation);
      reset = 1'b0;
   endtask
   // Prints the counts and the verdict, then ends the run.
   task automatic close_out();
      $display("mismatches %0d, checks %0d", n_mismatch, checks_done);
      if (n_mismatch == 0 && checks_done > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   // Main sequence of scenarios.
   initial begin
      {reset, linkActive, msaValid, timingValid, streamFlagsValid, blackDisable, auxRequest, lightOn} = 8'h80;
      streamFlags = 8'h00;
      pixelIn = PIX;
      gap = 8'h0d;
      restart();
      auxRequest = 1'b1;
      tick(1);
      check("aux reply", 1'b1, auxReply);
      tick(1);
      check("aux reply", 1'b1, auxReply);
      auxRequest = 1'b0;
      tick(1);
      check("aux reply", 1'b0, auxReply);
      tick(HPD - 6);
      check("hpd early", 1'b0, hotPlugDetect);
      tick(6);
      check("hpd", 1'b1, hotPlugDetect);
      check("aux ready", 1'b1, auxReady);
      aux_poll(auxAnswered);
      check("aux after hpd", 1'b1, auxAnswered);
      {linkActive, msaValid, timingValid} = 3'b111;
      flags(8'h00);
      check("black on good video", 1'b0, blackActive);
      check("pixel pass", PIX, pixelOut);
      check("status", 1'b1, sinkStatus);
      flags(8'h08);
      check("black on absent", 1'b1, blackActive);
      check("pixel black", '0, pixelOut);
      flags(8'hf7);
      check("black other bits", 1'b0, blackActive);
      for (int k = 0; k < 3; k++) begin
         {linkActive, msaValid, timingValid} = ~(3'b001 << k);
         tick(LOSS - 2);
         check("black early", 1'b0, blackActive);
         tick(6);
         check("black on loss", 1'b1, blackActive);
         check("pixel on loss", '0, pixelOut);
         {linkActive, msaValid, timingValid} = 3'b111;
         tick(3);
         check("black restored", 1'b0, blackActive);
      end
      blackDisable = 1'b1;
      linkActive = 1'b0;
      tick(LOSS + 6);
      check("black disabled", 1'b0, blackActive);
      check("pixel disabled", PIX, pixelOut);
      blackDisable = 1'b0;
      tick(LOSS + 4);
      check("black enabled", 1'b1, blackActive);
      linkActive = 1'b1;
      lightOn = 1'b1;
      tick(4 * GAP);
      lightOn = 1'b0;
      tick(4 * GAP);
      check("legal sequence", 1'b0, seqViolation);
      lightOn = 1'b1;
      tick(4 * GAP);
      check("legal power-up", 1'b0, seqViolation);
      gap = 8'h06;
      lightOn = 1'b0;
      tick(4 * GAP);
      check("short power-down", 1'b1, seqViolation);
      restart();
      lightOn = 1'b1;
      tick(4 * GAP);
      check("short gap", 1'b1, seqViolation);
      lightOn = 1'b0;
      tick(4 * GAP);
      restart();
      close_out();
   end
endmodule // pbs_panel_seq_bench
